// ===== apbsv_top.sv
// aperture base and subsystem vendor identifier configuration registers
//
// Contract
// [RULE1] aperture base is 32 bits and resets with only the prefetchable bit set.
// [RULE2] base bits 31:28 are read/write and compared with address bits 31:28.
// [RULE3] base bits 27:22 are writable except those the size select forces to zero.
// [RULE4] base bits 21:4 read zero and ignore writes, giving a 4 MB minimum.
// [RULE5] base bit 3 is constant one, marking the range prefetchable.
// [RULE6] aperture reads have no side effects and return every byte.
// [RULE7] several processor writes into the aperture may merge into one.
// [RULE8] base bits 2:1 read 00, placeable anywhere in 32-bit space.
// [RULE9] base bit 0 reads zero, a memory range.
// [RULE10] aperture accesses are blocked until config bit 9 is set.
// [RULE11] firmware programs the size select before generic software places the base.
// [RULE12] subsystem vendor id is 16 bits, resets to zero, and takes one write only.
// [RULE13] boot software should write the vendor id at start-up; later writes are lost.
// [RULE14] writes to read-only bits are discarded and reads have no side effects.
`timescale 1ns/100ps
`default_nettype none
`include "apbsv_regs.svh"
module apbsv_top (
    // clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        ARST_N_IN,
    // configuration access
    input  wire logic        CFG_WR_IN,
    input  wire logic        CFG_RD_IN,
    input  wire logic [7:0]  CFG_ADDR_IN,
    input  wire logic [3:0]  CFG_BE_IN,
    input  wire logic [31:0] CFG_WDATA_IN,
    output logic [31:0]      CFG_RDATA_OUT,
    output logic             CFG_RVALID_OUT,
    // size select and global enable from other config registers
    input  wire logic [5:0]  APERTURE_SIZE_SELECT_IN,
    input  wire logic [15:0] CONTROLLER_CONFIG_REG_IN,
    // memory access lookup
    input  wire logic        MEM_REQ_IN,
    input  wire logic [31:0] MEM_ADDR_IN,
    output logic             APERTURE_HIT_OUT,
    output logic             APERTURE_BLOCKED_OUT,
    output logic [31:0]      APERTURE_BASE_OUT
);
    logic [3:0]  upper_reg;
    logic [5:0]  mid_reg;
    logic [15:0] subsystem_vendor_identifier_reg;
    logic        subsystem_vendor_identifier_locked_reg;
    logic [31:0] base_view;
    logic        hit_comb;
    apbsv_pkg::apbsv_acc_t acc;

    // word-address match of the aligned word at a given offset, used for reads and writes
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
        wr_hit = (a[7:2] == ofs[7:2]);
    endfunction

    always_comb begin
        if (CFG_WR_IN)
            acc = apbsv_pkg::APBSV_WRITE;
        else if (CFG_RD_IN)
            acc = apbsv_pkg::APBSV_READ;
        else
            acc = apbsv_pkg::APBSV_IDLE;
    end

    // masked bits read zero; a write also stores masked bits as zero, but bits
    // stored before the mask was set reappear when it is cleared
    always_comb begin
        base_view = 32'h0000_0000;
        base_view[`APBSV_UPPER_HI:`APBSV_UPPER_LO] = upper_reg; // RULE2
        base_view[`APBSV_MID_HI:`APBSV_MID_LO] = mid_reg & ~APERTURE_SIZE_SELECT_IN; // RULE3
        base_view[`APBSV_PREFETCH_BIT] = 1'b1; // RULE5
        // bits 21:4, 2:1 and 0 stay zero RULE4 RULE8 RULE9
    end

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            upper_reg <= 4'(`APBSV_RST_APERTURE_BASE >> `APBSV_UPPER_LO); // RULE1
            mid_reg   <= 6'h00;
        end else if (acc == apbsv_pkg::APBSV_WRITE &&
                     wr_hit(CFG_ADDR_IN, `APBSV_OFS_APERTURE_BASE)) begin
            // only bytes 3 and 2 hold writable bits; lower bytes are read-only RULE14
            if (CFG_BE_IN[3])
                upper_reg <= CFG_WDATA_IN[31:28]; // RULE2
            if (CFG_BE_IN[3] && CFG_BE_IN[2])
                mid_reg <= CFG_WDATA_IN[27:22] & ~APERTURE_SIZE_SELECT_IN; // RULE3
            else if (CFG_BE_IN[3])
                mid_reg[5:2] <= CFG_WDATA_IN[27:24] & ~APERTURE_SIZE_SELECT_IN[5:2];
            else if (CFG_BE_IN[2])
                mid_reg[1:0] <= CFG_WDATA_IN[23:22] & ~APERTURE_SIZE_SELECT_IN[1:0];
        end
    end

    // write-once: first write with lane 0 or lane 1 enabled locks the field
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            subsystem_vendor_identifier_reg        <= `APBSV_RST_SUBSYS_VENDOR; // RULE12
            subsystem_vendor_identifier_locked_reg <= 1'b0;
        end else if (acc == apbsv_pkg::APBSV_WRITE && !subsystem_vendor_identifier_locked_reg &&
                     wr_hit(CFG_ADDR_IN, `APBSV_OFS_SUBSYS_VENDOR) &&
                     (CFG_BE_IN[1] || CFG_BE_IN[0])) begin
            if (CFG_BE_IN[0])
                subsystem_vendor_identifier_reg[7:0] <= CFG_WDATA_IN[7:0];
            if (CFG_BE_IN[1])
                subsystem_vendor_identifier_reg[15:8] <= CFG_WDATA_IN[15:8];
            subsystem_vendor_identifier_locked_reg <= 1'b1; // RULE12
        end
    end

    // reads return the full word regardless of byte enables, no side effects
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            CFG_RDATA_OUT  <= 32'h0000_0000;
            CFG_RVALID_OUT <= 1'b0;
        end else begin
            CFG_RVALID_OUT <= (acc == apbsv_pkg::APBSV_READ);
            if (acc != apbsv_pkg::APBSV_READ)
                CFG_RDATA_OUT <= 32'h0000_0000;
            else if (wr_hit(CFG_ADDR_IN, `APBSV_OFS_APERTURE_BASE))
                CFG_RDATA_OUT <= base_view; // RULE6 RULE14
            else if (wr_hit(CFG_ADDR_IN, `APBSV_OFS_SUBSYS_VENDOR))
                CFG_RDATA_OUT <= {16'h0000, subsystem_vendor_identifier_reg};
            else
                CFG_RDATA_OUT <= 32'h0000_0000;
        end
    end

    apbsv_decode u_decode (
        .upper_in     (upper_reg),
        .mid_in       (mid_reg),
        .size_mask_in (APERTURE_SIZE_SELECT_IN),
        .addr_in      (MEM_ADDR_IN),
        .enable_in    (MEM_REQ_IN && CONTROLLER_CONFIG_REG_IN[`APBSV_CFG_APEN_BIT]), // RULE10
        .hit_out      (hit_comb)
    );

    // range test ignores low bits, so merged writes into the aperture hit alike RULE7
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            APERTURE_HIT_OUT     <= 1'b0;
            APERTURE_BLOCKED_OUT <= 1'b1;
            APERTURE_BASE_OUT    <= `APBSV_RST_APERTURE_BASE;
        end else begin
            APERTURE_HIT_OUT     <= hit_comb; // RULE2
            APERTURE_BLOCKED_OUT <= !CONTROLLER_CONFIG_REG_IN[`APBSV_CFG_APEN_BIT]; // RULE10
            APERTURE_BASE_OUT    <= base_view;
        end
    end
endmodule
`default_nettype wire

// ===== apbsv_regs.svh
// register offsets, field positions, reset values for the aperture/subsystem bank
`ifndef APBSV_REGS_SVH
`define APBSV_REGS_SVH
`define APBSV_OFS_APERTURE_BASE   8'h10
`define APBSV_OFS_SUBSYS_VENDOR   8'h2C
`define APBSV_RST_APERTURE_BASE   32'h0000_0008
`define APBSV_RST_SUBSYS_VENDOR   16'h0000
`define APBSV_UPPER_HI            31
`define APBSV_UPPER_LO            28
`define APBSV_MID_HI              27
`define APBSV_MID_LO              22
`define APBSV_PREFETCH_BIT        3
`define APBSV_CFG_APEN_BIT        9
`define APBSV_MID_W               6
`endif

// ===== apbsv_pkg.sv
// types shared by the aperture/subsystem register bank
`default_nettype none
package apbsv_pkg;
    typedef enum logic [1:0] {
        APBSV_IDLE,
        APBSV_READ,
        APBSV_WRITE
    } apbsv_acc_t;
endpackage
`default_nettype wire

// ===== apbsv_decode.sv
// aperture address hit decoder
`timescale 1ns/100ps
`default_nettype none
`include "apbsv_regs.svh"
module apbsv_decode (
    // aperture base and mask
    input  wire logic [3:0]  upper_in,
    input  wire logic [5:0]  mid_in,
    input  wire logic [5:0]  size_mask_in,
    // address under test
    input  wire logic [31:0] addr_in,
    input  wire logic        enable_in,
    // result
    output logic             hit_out
);
    // bits selected by size act as don't-care in the compare
    logic [5:0] mid_match;
    genvar g;
    generate
        for (g = 0; g < `APBSV_MID_W; g = g + 1) begin : g_mid
            assign mid_match[g] = size_mask_in[g] |
                                  (mid_in[g] == addr_in[`APBSV_MID_LO + g]);
        end
    endgenerate
    assign hit_out = enable_in && (addr_in[31:28] == upper_in) && (&mid_match);
endmodule
`default_nettype wire

// ===== apbsv_monitor.sv
// concurrent checks on the register bank ports
`timescale 1ns/100ps
`default_nettype none
module apbsv_monitor (
    input wire logic        REF_CLK_IN,
    input wire logic        ARST_N_IN,
    input wire logic        CFG_RD_IN,
    input wire logic [7:0]  CFG_ADDR_IN,
    input wire logic [31:0] CFG_RDATA_OUT,
    input wire logic        CFG_RVALID_OUT,
    input wire logic [15:0] CONTROLLER_CONFIG_REG_IN,
    input wire logic        MEM_REQ_IN,
    input wire logic [31:0] MEM_ADDR_IN,
    input wire logic        APERTURE_HIT_OUT,
    input wire logic        APERTURE_BLOCKED_OUT,
    input wire logic [31:0] APERTURE_BASE_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    property p_low; APERTURE_BASE_OUT[21:0] == 22'h00_0008; endproperty
    a_low: assert property (p_low) else $error("base low bits");
    property p_rv; CFG_RD_IN |=> CFG_RVALID_OUT; endproperty
    a_rv: assert property (p_rv) else $error("no rvalid");
    property p_unm; CFG_RD_IN && CFG_ADDR_IN[7:2] != 6'h04 && CFG_ADDR_IN[7:2] != 6'h0B
        |=> CFG_RDATA_OUT == 32'h0000_0000; endproperty
    a_unm: assert property (p_unm) else $error("unmapped data");
    property p_blk; 1 |=> APERTURE_BLOCKED_OUT == !$past(CONTROLLER_CONFIG_REG_IN[9]); endproperty
    a_blk: assert property (p_blk) else $error("blocked flag");
    property p_h0; APERTURE_HIT_OUT |-> $past(MEM_REQ_IN) && $past(CONTROLLER_CONFIG_REG_IN[9]);
    endproperty
    a_h0: assert property (p_h0) else $error("hit while off");
    property p_h1; MEM_REQ_IN && CONTROLLER_CONFIG_REG_IN[9]
        && MEM_ADDR_IN[31:22] == APERTURE_BASE_OUT[31:22] |=> APERTURE_HIT_OUT; endproperty
    a_h1: assert property (p_h1) else $error("missed hit");
    property p_miss; MEM_ADDR_IN[31:28] != APERTURE_BASE_OUT[31:28] |=> !APERTURE_HIT_OUT;
    endproperty
    a_miss: assert property (p_miss) else $error("false hit");
    property p_pair; CFG_RVALID_OUT |=> !CFG_RVALID_OUT || $past(CFG_RD_IN); endproperty
    a_pair: assert property (p_pair) else $error("rvalid too long");
endmodule
`default_nettype wire

// ===== apbsv_top_tb.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module apbsv_top_tb;
    // port names kept so the instance connects by name
    logic        REF_CLK_IN = 0, ARST_N_IN = 0, CFG_WR_IN = 0, CFG_RD_IN = 0, MEM_REQ_IN = 0;
    logic [7:0]  CFG_ADDR_IN = 8'h00;
    logic [3:0]  CFG_BE_IN = 4'h0;
    logic [31:0] CFG_WDATA_IN = 32'h0000_0000, MEM_ADDR_IN = 32'h0000_0000;
    logic [5:0]  APERTURE_SIZE_SELECT_IN = 6'h00;
    logic [15:0] CONTROLLER_CONFIG_REG_IN = 16'h0000;
    wire logic [31:0] CFG_RDATA_OUT, APERTURE_BASE_OUT;
    wire logic        CFG_RVALID_OUT, APERTURE_HIT_OUT, APERTURE_BLOCKED_OUT;
    int errors = 0, check_count = 0;
    apbsv_top dut (.*);
    initial forever #2 REF_CLK_IN = ~REF_CLK_IN;
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(negedge REF_CLK_IN);
        {CFG_WR_IN, CFG_ADDR_IN, CFG_BE_IN, CFG_WDATA_IN} = {1'b1, a, b, d};
        @(negedge REF_CLK_IN);
        CFG_WR_IN = 0;
    endtask
    // byte enables left at zero: a read still returns the whole word
    task rd(input string n, input logic [7:0] a, input logic [31:0] e);
        @(negedge REF_CLK_IN);
        {CFG_RD_IN, CFG_ADDR_IN, CFG_BE_IN} = {1'b1, a, 4'h0};
        @(negedge REF_CLK_IN);
        CFG_RD_IN = 0;
        chk("rvalid", {31'h0, CFG_RVALID_OUT}, 32'h0000_0001);
        chk(n, CFG_RDATA_OUT, e);
    endtask
    task lk(input logic [31:0] a, input logic e);
        @(negedge REF_CLK_IN);
        {MEM_REQ_IN, MEM_ADDR_IN} = {1'b1, a};
        @(negedge REF_CLK_IN);
        MEM_REQ_IN = 0;
        chk("hit", {31'h0, APERTURE_HIT_OUT}, {31'h0, e});
    endtask
    task t_reset;
        chk("blocked", {31'h0, APERTURE_BLOCKED_OUT}, 32'h0000_0001);
        rd("base", 8'h10, 32'h0000_0008);
        rd("vid", 8'h2C, 32'h0000_0000);
    endtask
    task t_base;
        wr(8'h10, 4'hF, 32'hFFFF_FFFF);
        rd("base", 8'h10, 32'hFFC0_0008);
        wr(8'h10, 4'h8, 32'h0000_0000);
        rd("base", 8'h13, 32'h00C0_0008);
        APERTURE_SIZE_SELECT_IN = 6'h0F;
        wr(8'h10, 4'hF, 32'hFFFF_FFFF);
        rd("base", 8'h10, 32'hFC00_0008);
        chk("base_out", APERTURE_BASE_OUT, 32'hFC00_0008);
    endtask
    task t_hit;
        lk(32'hFC00_0000, 1'b0);
        CONTROLLER_CONFIG_REG_IN = 16'h0200;
        lk(32'hFC00_0000, 1'b1);
        chk("blocked", {31'h0, APERTURE_BLOCKED_OUT}, 32'h0000_0000);
        lk(32'hFD40_0000, 1'b1);
        lk(32'h7C00_0000, 1'b0);
        lk(32'hF800_0000, 1'b0);
    endtask
    task t_vid;
        wr(8'h2C, 4'h3, 32'h0000_1234);
        rd("vid", 8'h2C, 32'h0000_1234);
        wr(8'h2C, 4'h3, 32'h0000_ABCD);
        rd("vid", 8'h2C, 32'h0000_1234);
        rd("none", 8'h40, 32'h0000_0000);
    endtask
    task final_report;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge REF_CLK_IN);
        ARST_N_IN = 1;
        t_reset();
        t_base();
        t_hit();
        t_vid();
        final_report();
    end
endmodule
bind apbsv_top apbsv_monitor u_mon (.*);
`default_nettype wire
